//--- rtl/ubm_boot_select.sv
// Purpose: picks the boot path after reset, loads a ram image, holds the cpu and bus link
// Assumes: eeprom reader answers each held request with ack or nack
// Notes: registers on classic wishbone, one wait state per access
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ubm_params.svh"

// Notes on behaviour
// - request bit zero: default device answers
// - no memory: default ids, bit zero
// - 0xc0 marker: eeprom ids, bit zero
// - 0xc2 marker: eeprom holds firmware image
// - image copied, cpu reset from image's cpu control byte, bit one
// - eeprom to 64 KB, writes only 16K ram
// - external memory and pin high: bit one
// - default device follows detected speed
// - one configuration, interface 0, alts 0-3
// - alt zero has only control endpoint
// - full speed endpoints all 64 bytes
// - high speed ep2/4/6/8 512, doubled
// - high speed alt1 ep1 reported 512
// - download into ram before firmware exists
// - firmware can disconnect and reconnect
// - unknown marker treated as no eeprom
// - record: final flag with length, address, data
module ubm_boot_select #(
	parameter logic [15:0] DEF_VID = 16'h1234, // arbitrary value
	parameter logic [15:0] DEF_PID = 16'h5678, // arbitrary value
	parameter logic [15:0] DEF_REL = 16'ha001  // arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic eep_req,
	output logic [15:0] eep_addr,
	input wire logic [7:0] eep_data,
	input wire logic eep_ack,
	input wire logic eep_nack,
	input wire logic ext_mem_present,
	input wire logic external_code_select_pin,
	input wire logic speed_hs_detected,
	output logic ram_we,
	output logic [15:0] ram_addr,
	output logic [7:0] ram_wdata,
	output logic cpu_reset,
	output logic usb_connect,
	output logic firmware_request_handling_bit,
	output logic usb_high_speed,
	output logic [15:0] desc_vid,
	output logic [15:0] desc_pid,
	output logic [15:0] desc_rel,
	output logic [15:0] ext_start_addr
);
	typedef enum logic [2:0] {S_START, S_MARK, S_IDS, S_HDR, S_DATA, S_DONE} ubm_state_type;

	ubm_state_type state_q; // loader state
	ubm_pkg::ubm_path_type path_q; // chosen boot path
	logic [2:0] idx_q; // byte index inside a group
	logic [7:0] ids_q [0:5]; // eeprom id bytes, low first
	logic [9:0] len_q; // bytes left in record
	logic [15:0] rec_addr_q; // target address of next byte
	logic final_q; // current record is the last
	logic finish_q; // one-cycle pulse at end of selection
	logic done_q; // selection complete
	logic ld_we_q; // loader write strobe
	logic [15:0] ld_addr_q;
	logic [7:0] ld_data_q;
	logic ld_cpu_q; // cpu reset bit written by the image
	logic hs_q; // registered speed result
	logic [1:0] q_alt_q; // endpoint query alt setting
	logic [2:0] q_ep_q; // endpoint query endpoint
	logic [9:0] ep_mps;
	ubm_pkg::ubm_ep_kind_type ep_kind;
	logic ep_dbl;
	logic wr_en; // write takes effect this edge
	logic [5:0] reg_off;
	logic [31:0] rd_data;
	logic byte_taken;

	////////////////////////////////////////////////////////////
	// helpers
	// only on-chip ram may be written
	function automatic logic ram_ok(input logic [15:0] a);
		ram_ok = (a <= `UBM_RAM_TOP);
	endfunction

	function automatic ubm_pkg::ubm_path_type fallback(input logic ext, input logic sel);
		fallback = (ext && sel) ? ubm_pkg::UBM_PATH_EXT : ubm_pkg::UBM_PATH_NONE;
	endfunction

	assign byte_taken = eep_req && eep_ack;
	assign reg_off = wb_adr_i[5:0];
	// writes land on the edge that sees ack high
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

	////////////////////////////////////////////////////////////
	// eeprom loader, runs once after reset
	// single pass after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= S_START;
			path_q <= ubm_pkg::UBM_PATH_NONE;
			eep_req <= 1'b0;
			eep_addr <= 16'h0000;
			idx_q <= 3'h0;
			len_q <= 10'h000;
			rec_addr_q <= 16'h0000;
			final_q <= 1'b0;
			finish_q <= 1'b0;
			ld_we_q <= 1'b0;
			ld_addr_q <= 16'h0000;
			ld_data_q <= 8'h00;
		end else begin
			finish_q <= 1'b0;
			ld_we_q <= 1'b0;
			// re-issue a read one idle cycle after each byte
			if (state_q != S_START && state_q != S_DONE && !eep_req) begin
				eep_req <= 1'b1;
			end
			case (state_q)
				// first read at eeprom address zero
				S_START: begin
					eep_req <= 1'b1;
					eep_addr <= 16'h0000;
					state_q <= S_MARK;
				end
				// marker byte decides path
				S_MARK: begin
					if (eep_req && eep_nack) begin
						eep_req <= 1'b0;
						path_q <= fallback(ext_mem_present, external_code_select_pin);
						state_q <= S_DONE;
						finish_q <= 1'b1;
					end else if (byte_taken) begin
						eep_req <= 1'b0;
						eep_addr <= eep_addr + 16'h0001;
						idx_q <= 3'h0;
						if (eep_data == `UBM_MARK_ID) begin
							path_q <= ubm_pkg::UBM_PATH_ID;
							state_q <= S_IDS;
						end else if (eep_data == `UBM_MARK_IMG) begin
							path_q <= ubm_pkg::UBM_PATH_IMG;
							state_q <= S_IDS;
						end else begin
							path_q <= fallback(ext_mem_present, external_code_select_pin);
							state_q <= S_DONE;
							finish_q <= 1'b1;
						end
					end
				end
				// six id bytes then the configuration byte
				S_IDS: begin
					if (eep_req && eep_nack) begin
						eep_req <= 1'b0;
						state_q <= S_DONE;
						finish_q <= 1'b1;
					end else if (byte_taken) begin
						eep_req <= 1'b0;
						eep_addr <= eep_addr + 16'h0001;
						idx_q <= idx_q + 3'h1;
						if (idx_q == `UBM_ID_BYTES) begin
							idx_q <= 3'h0;
							// configuration byte is not acted on here
							if (path_q == ubm_pkg::UBM_PATH_ID) begin
								state_q <= S_DONE;
								finish_q <= 1'b1;
							end else begin
								state_q <= S_HDR;
							end
						end
					end
				end
				S_HDR: begin
					if (eep_req && eep_nack) begin
						eep_req <= 1'b0;
						state_q <= S_DONE;
						finish_q <= 1'b1;
					end else if (byte_taken) begin
						eep_req <= 1'b0;
						eep_addr <= eep_addr + 16'h0001;
						idx_q <= idx_q + 3'h1;
						case (idx_q)
							3'h0: begin
								final_q <= eep_data[`UBM_HDR_FINAL_BIT];
								len_q[9:8] <= eep_data[1:0];
							end
							3'h1: len_q[7:0] <= eep_data;
							3'h2: rec_addr_q[15:8] <= eep_data;
							default: begin
								rec_addr_q[7:0] <= eep_data;
								idx_q <= 3'h0;
								if (len_q != 10'h000) begin
									state_q <= S_DATA;
								end else if (final_q) begin
									state_q <= S_DONE;
									finish_q <= 1'b1;
								end
							end
						endcase
						// stop at the end of a 64 KB eeprom
						if (eep_addr == `UBM_EEP_LAST) begin
							state_q <= S_DONE;
							finish_q <= 1'b1;
						end
					end
				end
				S_DATA: begin
					if (eep_req && eep_nack) begin
						eep_req <= 1'b0;
						state_q <= S_DONE;
						finish_q <= 1'b1;
					end else if (byte_taken) begin
						eep_req <= 1'b0;
						eep_addr <= eep_addr + 16'h0001;
						ld_we_q <= 1'b1;
						ld_addr_q <= rec_addr_q;
						ld_data_q <= eep_data;
						rec_addr_q <= rec_addr_q + 16'h0001;
						len_q <= len_q - 10'h001;
						if (len_q == 10'h001) begin
							state_q <= final_q ? S_DONE : S_HDR;
							finish_q <= final_q;
						end
						if (eep_addr == `UBM_EEP_LAST) begin
							state_q <= S_DONE;
							finish_q <= 1'b1;
						end
					end
				end
				S_DONE: begin
					eep_req <= 1'b0;
				end
				default: begin
					state_q <= S_DONE;
				end
			endcase
		end
	end

	// id bytes captured apart from the sequencer
	always_ff @(posedge clk) begin
		if (state_q == S_IDS && byte_taken && idx_q < `UBM_ID_BYTES) begin
			ids_q[idx_q] <= eep_data;
		end
	end

	////////////////////////////////////////////////////////////
	// selection result, request bit, identifiers
	always_ff @(posedge clk) begin
		if (rst) begin
			done_q <= 1'b0;
			firmware_request_handling_bit <= `UBM_REQ_RST;
			desc_vid <= DEF_VID;
			desc_pid <= DEF_PID;
			desc_rel <= DEF_REL;
			ext_start_addr <= `UBM_EXT_START;
		end else if (finish_q) begin
			done_q <= 1'b1;
			firmware_request_handling_bit <= (path_q == ubm_pkg::UBM_PATH_IMG) || (path_q == ubm_pkg::UBM_PATH_EXT);
			if (path_q == ubm_pkg::UBM_PATH_ID) begin
				desc_vid <= {ids_q[1], ids_q[0]};
				desc_pid <= {ids_q[3], ids_q[2]};
				desc_rel <= {ids_q[5], ids_q[4]};
			end
		end else if (wr_en && done_q && reg_off == `UBM_REG_CONNECT) begin
			firmware_request_handling_bit <= wb_dat_i[`UBM_CN_REQ];
		end
	end

	////////////////////////////////////////////////////////////
	// cpu hold, link connect, speed
	// a pending image write to cpu control only acts once selection ends
	always_ff @(posedge clk) begin
		if (rst) begin
			ld_cpu_q <= `UBM_CPU_RESET_RST;
			cpu_reset <= `UBM_CPU_RESET_RST;
			usb_connect <= `UBM_CONNECT_RST;
			hs_q <= 1'b0;
			usb_high_speed <= 1'b0;
		end else begin
			hs_q <= speed_hs_detected;
			usb_high_speed <= hs_q;
			if (ld_we_q && ld_addr_q == `UBM_CPU_CTRL_ADDR) begin
				ld_cpu_q <= ld_data_q[`UBM_CPU_RESET_BIT];
			end
			if (finish_q) begin
				usb_connect <= 1'b1;
				if (path_q == ubm_pkg::UBM_PATH_IMG) begin
					// last image byte may land with the finish pulse
					if (ld_we_q && ld_addr_q == `UBM_CPU_CTRL_ADDR) begin
						cpu_reset <= ld_data_q[`UBM_CPU_RESET_BIT];
					end else begin
						cpu_reset <= ld_cpu_q;
					end
				end else if (path_q == ubm_pkg::UBM_PATH_EXT) begin
					cpu_reset <= 1'b0;
				end
			end else if (wr_en && done_q) begin
				// host holds and frees the cpu
				if (reg_off == `UBM_REG_CPU_CTRL) begin
					cpu_reset <= wb_dat_i[`UBM_CPU_RESET_BIT];
				end
				if (reg_off == `UBM_REG_CONNECT) begin
					usb_connect <= wb_dat_i[`UBM_CN_CONNECT];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////
	// ram write port shared by loader and host download
	always_ff @(posedge clk) begin
		if (rst) begin
			ram_we <= 1'b0;
			ram_addr <= 16'h0000;
			ram_wdata <= 8'h00;
		end else begin
			ram_we <= 1'b0;
			if (ld_we_q && ram_ok(ld_addr_q)) begin
				ram_we <= 1'b1;
				ram_addr <= ld_addr_q;
				ram_wdata <= ld_data_q;
			end else if (wr_en && done_q && cpu_reset && reg_off == `UBM_REG_DOWNLOAD &&
				ram_ok(wb_dat_i[31:16])) begin
				ram_we <= 1'b1;
				ram_addr <= wb_dat_i[31:16];
				ram_wdata <= wb_dat_i[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////
	// default device endpoint personality
	// one interface, four alt settings
	ubm_ep_table u_ep_table (
		.high_speed(usb_high_speed),
		.alt(q_alt_q),
		.ep_sel(q_ep_q),
		.mps(ep_mps),
		.kind(ep_kind),
		.dbl(ep_dbl)
	);

	// endpoint query select register
	always_ff @(posedge clk) begin
		if (rst) begin
			q_alt_q <= 2'h0;
			q_ep_q <= 3'h0;
		end else if (wr_en && reg_off == `UBM_REG_EP_QUERY) begin
			q_alt_q <= wb_dat_i[1:0];
			q_ep_q <= wb_dat_i[6:4];
		end
	end

	////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after request, unmapped reads zero
	always_comb begin
		case (reg_off)
			`UBM_REG_STATUS: rd_data = {26'h0, cpu_reset, usb_high_speed, firmware_request_handling_bit,
				done_q, 2'(path_q)};
			`UBM_REG_CPU_CTRL: rd_data = {31'h0, cpu_reset};
			`UBM_REG_IDS: rd_data = {desc_pid, desc_vid};
			`UBM_REG_DEV_REL: rd_data = {16'h0, desc_rel};
			`UBM_REG_CONNECT: rd_data = {30'h0, firmware_request_handling_bit, usb_connect};
			`UBM_REG_EP_QUERY: rd_data = {16'h0, ep_dbl, 3'(ep_kind), 2'h0, ep_mps};
			default: rd_data = 32'h0;
		endcase
	end

	// ack and read data registered together
	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= rd_data;
			end
		end
	end

	////////////////////////////////////////////////////////////
	// checks
	ack_single_a: assert property (@(posedge clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
	hold_until_done_a: assert property (@(posedge clk) disable iff (rst)
		!done_q |-> cpu_reset && !usb_connect) else $error("cpu or link released before selection");
	id_boot_bit_a: assert property (@(posedge clk) disable iff (rst)
		finish_q && path_q == ubm_pkg::UBM_PATH_ID |=> !firmware_request_handling_bit &&
		desc_vid == {ids_q[1], ids_q[0]}) else $error("id-only boot result wrong");
	img_boot_bit_a: assert property (@(posedge clk) disable iff (rst)
		finish_q && path_q == ubm_pkg::UBM_PATH_IMG |=> firmware_request_handling_bit) else $error("image boot bit");
	none_boot_bit_a: assert property (@(posedge clk) disable iff (rst)
		finish_q && path_q == ubm_pkg::UBM_PATH_NONE |=> !firmware_request_handling_bit && desc_vid == DEF_VID)
		else $error("no-memory boot result wrong");
	ext_boot_a: assert property (@(posedge clk) disable iff (rst)
		finish_q && path_q == ubm_pkg::UBM_PATH_EXT |=> firmware_request_handling_bit && !cpu_reset)
		else $error("external boot result wrong");
	ram_range_a: assert property (@(posedge clk) disable iff (rst)
		ram_we |-> ram_addr <= `UBM_RAM_TOP) else $error("ram write outside on-chip ram");
	bad_marker_a: assert property (@(posedge clk) disable iff (rst)
		state_q == S_MARK && byte_taken && eep_data != `UBM_MARK_ID && eep_data != `UBM_MARK_IMG |=>
		finish_q && path_q != ubm_pkg::UBM_PATH_ID && path_q != ubm_pkg::UBM_PATH_IMG)
		else $error("unknown marker not treated as absent");
	alt_zero_a: assert property (@(posedge clk) disable iff (rst)
		q_alt_q == 2'h0 && q_ep_q != 3'h0 |-> ep_mps == 10'h000 && ep_kind == ubm_pkg::UBM_EP_NONE)
		else $error("alt zero reports data endpoint");
	hs_ep1_a: assert property (@(posedge clk) disable iff (rst)
		usb_high_speed && q_alt_q == 2'h1 && q_ep_q == 3'h1 |-> ep_mps == `UBM_HS_MPS)
		else $error("high speed alt1 ep1 size");

	id_boot_c: cover property (@(posedge clk) finish_q && path_q == ubm_pkg::UBM_PATH_ID);
	img_boot_c: cover property (@(posedge clk) finish_q && path_q == ubm_pkg::UBM_PATH_IMG);
	download_c: cover property (@(posedge clk) ram_we && done_q);
endmodule

//--- include/ubm_params.svh
// Purpose: offsets, field positions, reset values and markers of the boot selector
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef UBM_PARAMS_SVH
`define UBM_PARAMS_SVH

// register byte offsets on the wishbone slave
`define UBM_REG_STATUS 6'h00
`define UBM_REG_CPU_CTRL 6'h04
`define UBM_REG_IDS 6'h08
`define UBM_REG_DEV_REL 6'h0c
`define UBM_REG_CONNECT 6'h10
`define UBM_REG_EP_QUERY 6'h14
`define UBM_REG_DOWNLOAD 6'h18

// field positions
`define UBM_ST_DONE 2
`define UBM_ST_REQ 3
`define UBM_ST_HS 4
`define UBM_ST_CPURST 5
`define UBM_CN_CONNECT 0
`define UBM_CN_REQ 1
`define UBM_CPU_RESET_BIT 0
`define UBM_HDR_FINAL_BIT 7

// reset values
`define UBM_CPU_RESET_RST 1'b1
`define UBM_CONNECT_RST 1'b0
`define UBM_REQ_RST 1'b0

// eeprom markers and memory map
`define UBM_MARK_ID 8'hc0
`define UBM_MARK_IMG 8'hc2
`define UBM_EEP_LAST 16'hffff
`define UBM_RAM_TOP 16'h3fff
`define UBM_CPU_CTRL_ADDR 16'he600
`define UBM_EXT_START 16'h0000
`define UBM_ID_BYTES 3'd6

// endpoint packet sizes
`define UBM_EP0_MPS 10'h040
`define UBM_FS_MPS 10'h040
`define UBM_HS_MPS 10'h200

`endif

//--- include/ubm_pkg.sv
// Purpose: shared types of the boot selector
// Assumes: nothing
// Notes: constants live in ubm_params.svh
package ubm_pkg;
	// boot path chosen after reset
	typedef enum logic [1:0] {
		UBM_PATH_NONE,
		UBM_PATH_ID,
		UBM_PATH_IMG,
		UBM_PATH_EXT
	} ubm_path_type;

	// endpoint transfer kind reported by the default device
	typedef enum logic [2:0] {
		UBM_EP_NONE,
		UBM_EP_CTRL,
		UBM_EP_BULK,
		UBM_EP_INT,
		UBM_EP_ISO
	} ubm_ep_kind_type;
endpackage

//--- rtl/ubm_ep_table.sv
// Purpose: endpoint personality of the built-in default device
// Assumes: ep select 0=ep0 1=ep1out 2=ep1in 3=ep2 4=ep4 5=ep6 6=ep8
// Notes: purely combinational, the caller registers the answer
`timescale 1ns/1ps
`include "ubm_params.svh"

module ubm_ep_table (
	input wire logic high_speed,
	input wire logic [1:0] alt,
	input wire logic [2:0] ep_sel,
	output logic [9:0] mps,
	output ubm_pkg::ubm_ep_kind_type kind,
	output logic dbl
);
	// size of ep2-ep8 and of alt 1 ep1 follows detected speed
	logic [9:0] data_mps;

	////////////////////////////////////////////////////////////
	// lookup
	// data sizes follow speed: 512 high, 64 full
	assign data_mps = high_speed ? `UBM_HS_MPS : `UBM_FS_MPS;

	// decode per endpoint and alternate setting
	always_comb begin
		mps = 10'h000;
		kind = ubm_pkg::UBM_EP_NONE;
		dbl = 1'b0;
		if (ep_sel == 3'h0) begin
			mps = `UBM_EP0_MPS;
			kind = ubm_pkg::UBM_EP_CTRL;
		end else if (alt != 2'h0) begin
			case (ep_sel)
				3'h1, 3'h2: begin
					mps = (alt == 2'h1) ? data_mps : `UBM_FS_MPS;
					kind = (alt == 2'h1) ? ubm_pkg::UBM_EP_BULK : ubm_pkg::UBM_EP_INT;
				end
				// ep2 and ep6 change kind per setting
				3'h3, 3'h5: begin
					mps = data_mps;
					dbl = 1'b1;
					case (alt)
						2'h1: kind = ubm_pkg::UBM_EP_BULK;
						2'h2: kind = ubm_pkg::UBM_EP_INT;
						default: kind = ubm_pkg::UBM_EP_ISO;
					endcase
				end
				// ep4 and ep8 always bulk
				3'h4, 3'h6: begin
					mps = data_mps;
					dbl = 1'b1;
					kind = ubm_pkg::UBM_EP_BULK;
				end
				// no such endpoint
				default: begin
					mps = 10'h000;
				end
			endcase
		end
	end
endmodule

//--- sim/ubm_eeprom_model.sv
// Purpose: behavioural serial boot eeprom on the byte read handshake
// Assumes: bench fills mem by hierarchy before reset is released
// Notes: absent answers nack, slow stretches each answer
`timescale 1ns/1ps

module ubm_eeprom_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic absent,
	input wire logic slow,
	input wire logic eep_req,
	input wire logic [15:0] eep_addr,
	output logic [7:0] eep_data,
	output logic eep_ack,
	output logic eep_nack
);
	// full 64 KB byte space, blank cells read ff
	logic [7:0] mem [0:65535];
	// cycles already waited on the held request
	logic [1:0] wait_q;

	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
	end

	////////////////////////////////////////////////////////////////////////////////
	// answer one held request, then drop the pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			eep_ack <= 1'b0;
			eep_nack <= 1'b0;
			eep_data <= 8'h00;
			wait_q <= 2'h0;
		end else if (eep_ack || eep_nack) begin
			// data line not held after the answer, so show garbage
			eep_ack <= 1'b0;
			eep_nack <= 1'b0;
			eep_data <= ~eep_data;
			wait_q <= 2'h0;
		end else if (eep_req && wait_q < (slow ? 2'h3 : 2'h0)) begin
			wait_q <= wait_q + 2'h1;
		end else if (eep_req && absent) begin
			eep_nack <= 1'b1;
		end else if (eep_req) begin
			eep_ack <= 1'b1;
			eep_data <= mem[eep_addr];
		end
	end
endmodule

//--- sim/usb_boot_mode_select_tb.sv
// Purpose: boot path, host download and endpoint table tests
// Assumes: wishbone answers every access with ack, any number of wait states
// Notes: every boot case is a fresh reset
`timescale 1ns/1ps
`include "ubm_params.svh"

module usb_boot_mode_select_tb;
	localparam logic [15:0] VID = 16'h1357; // arbitrary value
	localparam logic [15:0] PID = 16'h2468; // arbitrary value
	localparam logic [15:0] REL = 16'ha005; // arbitrary value
	// eeprom bytes 1..23: ids, config, three records
	localparam logic [7:0] ROM [1:23] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h00,
		8'h00, 8'h02, 8'h00, 8'h20, 8'ha1, 8'hb2, 8'h00, 8'h01, 8'h40, 8'h00, 8'hc3,
		8'h80, 8'h01, 8'he6, 8'h00, 8'h00};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic absent = 1'b0, slow = 1'b0, ext = 1'b0, pin = 1'b0, hs = 1'b0;
	wire [31:0] rdat;
	wire ack, ereq, eack, enack, ram_we, cpu_rst, conn, req_bit, usb_hs;
	wire [15:0] eaddr, ram_addr, vid, pid, rel, ext_adr;
	wire [7:0] edata, ram_wd;
	int failures = 0;
	int comparisons = 0;
	// ram writes seen, {addr, data}
	logic [23:0] ram_q [$];

	always #2.5 clk = ~clk;

	ubm_boot_select #(.DEF_VID(VID), .DEF_PID(PID), .DEF_REL(REL)) DUT (
		.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
		.eep_req(ereq), .eep_addr(eaddr), .eep_data(edata), .eep_ack(eack), .eep_nack(enack),
		.ext_mem_present(ext), .external_code_select_pin(pin), .speed_hs_detected(hs),
		.ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wd), .cpu_reset(cpu_rst),
		.usb_connect(conn), .firmware_request_handling_bit(req_bit), .usb_high_speed(usb_hs),
		.desc_vid(vid), .desc_pid(pid), .desc_rel(rel), .ext_start_addr(ext_adr));

	ubm_eeprom_model eep (.clk(clk), .rst(rst), .absent(absent), .slow(slow), .eep_req(ereq),
		.eep_addr(eaddr), .eep_data(edata), .eep_ack(eack), .eep_nack(enack));

	////////////////////////////////////////////////////////////////////////////////
	// log every ram write pulse
	always @(posedge clk) begin
		if (ram_we === 1'b1) ram_q.push_back({ram_addr, ram_wd});
	end

	task test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task wb(input logic [7:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		adr <= a;
		dat <= d;
		we <= w;
		sel <= 4'hf;
		// no cycle count assumed, only the watchdog ends a wait
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(a, d, 1'b1, q);
		@(posedge clk);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] q);
		wb(a, 32'h0, 1'b0, q);
	endtask

	// reset, boot with the given surroundings, check status
	task boot(input logic a, input logic [7:0] mk, input logic e, p, s, h,
		input logic [1:0] path, input logic rq, cr);
		logic [31:0] q;
		int n;
		rst <= 1'b1;
		absent <= a;
		ext <= e;
		pin <= p;
		slow <= s;
		hs <= h;
		eep.mem[0] = mk;
		ram_q.delete();
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(cpu_rst, 1'b1);
		check(conn, 1'b0);
		q = 32'h0;
		n = 0;
		while (q[`UBM_ST_DONE] !== 1'b1 && n < 300) begin
			rd(`UBM_REG_STATUS, q);
			n++;
		end
		check(q & 32'h3f, {26'h0, cr, h, rq, 1'b1, path});
		check(req_bit, rq);
		check(conn, 1'b1);
	endtask

	// endpoint answer expected from the default tables
	function automatic logic [31:0] ep_exp(input int h, input int alt, input int ep);
		logic [9:0] m;
		logic [2:0] k;
		logic d;
		m = 10'h0;
		k = ubm_pkg::UBM_EP_NONE;
		d = 1'b0;
		if (ep == 0) begin
			m = `UBM_EP0_MPS;
			k = ubm_pkg::UBM_EP_CTRL;
		end else if (alt != 0) begin
			m = (h != 0) ? `UBM_HS_MPS : `UBM_FS_MPS;
			k = ubm_pkg::UBM_EP_BULK;
			d = (ep > 2);
			// ep1 is small interrupt outside alt 1
			if (ep < 3 && alt != 1) begin
				m = `UBM_FS_MPS;
				k = ubm_pkg::UBM_EP_INT;
			end
			if ((ep == 3 || ep == 5) && alt == 2) k = ubm_pkg::UBM_EP_INT;
			if ((ep == 3 || ep == 5) && alt == 3) k = ubm_pkg::UBM_EP_ISO;
		end
		return {16'h0, d, k, 2'b00, m};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [31:0] q;
		boot(1'b1, 8'hff, 1'b0, 1'b1, 1'b0, 1'b0, 2'd0, 1'b0, 1'b1);
		check({vid, pid}, {VID, PID});
		check(rel, REL);
		// eeprom image layout, filled after the model's blank fill at time zero
		for (int i = 1; i <= 23; i++) eep.mem[i] = ROM[i];
		boot(1'b1, 8'hff, 1'b1, 1'b0, 1'b0, 1'b1, 2'd0, 1'b0, 1'b1);
		boot(1'b1, 8'hff, 1'b1, 1'b1, 1'b0, 1'b0, 2'd3, 1'b1, 1'b0);
		check(ext_adr, `UBM_EXT_START);
		boot(1'b0, 8'h55, 1'b0, 1'b0, 1'b1, 1'b1, 2'd0, 1'b0, 1'b1);
		check(vid, VID);
		boot(1'b0, `UBM_MARK_ID, 1'b0, 1'b0, 1'b0, 1'b1, 2'd1, 1'b0, 1'b1);
		check({vid, pid, rel}, 48'h2211_4433_6655);
		rd(`UBM_REG_IDS, q);
		check(q, 32'h4433_2211);
		rd(8'h3c, q);
		check(q, 32'h0);
		// host holds cpu, downloads, releases
		wr(`UBM_REG_CPU_CTRL, 32'h1);
		wr(`UBM_REG_DOWNLOAD, 32'h0100_00a5);
		wr(`UBM_REG_DOWNLOAD, 32'h4000_005a);
		wr(`UBM_REG_CPU_CTRL, 32'h0);
		check(cpu_rst, 1'b0);
		wr(`UBM_REG_DOWNLOAD, 32'h0200_0077);
		check(ram_q.size(), 1);
		check(ram_q[0], 24'h0100a5);
		wr(`UBM_REG_CONNECT, 32'h0);
		check(conn, 1'b0);
		wr(`UBM_REG_CONNECT, 32'h3);
		check({conn, req_bit}, 2'b11);
		boot(1'b0, `UBM_MARK_IMG, 1'b0, 1'b0, 1'b1, 1'b0, 2'd2, 1'b1, 1'b0);
		check(ram_q.size(), 2);
		check({ram_q[0], ram_q[1]}, 48'h0020a1_0021b2);
		// endpoint personality at both speeds
		for (int h = 0; h < 2; h++) begin
			hs <= h[0];
			repeat (3) @(posedge clk);
			check(usb_hs, h[0]);
			for (int a = 0; a < 4; a++) begin
				for (int e = 0; e < 7; e++) begin
					wr(`UBM_REG_EP_QUERY, {25'h0, e[2:0], 2'b00, a[1:0]});
					rd(`UBM_REG_EP_QUERY, q);
					// host side keeps ep1 packets within 64 bytes whatever size is reported
					check(q, ep_exp(h, a, e));
				end
			end
		end
		test_done;
	end

	// hang guard, about thirty times the expected run of some seven hundred cycles
	initial begin
		#100000;
		failures++;
		test_done;
	end
endmodule
